// [inc/sdc_pkg.sv]
// Shared constants, types and address mapping of the SDRAM user port
package sdc_pkg;
  // Request operation codes
  localparam logic [2:0] OP_WR  = 3'h0;
  localparam logic [2:0] OP_RD  = 3'h1;
  localparam logic [2:0] OP_WRB = 3'h3;

  // Register offsets, bytes
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control field positions and reset values
  localparam int         CTRL_AUTO_PRE = 0;
  localparam int         CTRL_USER_MNT = 1;
  localparam int         CTRL_MAP_X8   = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;

  // Status layout: [0] calibrated, [15:8] reads open, [23:16] writes open
  localparam int CNT_W = 8;

  // Timing
  localparam int CLK_NS         = 10;
  localparam int REFI_NS        = 7800;
  localparam int REFI_CYC       = REFI_NS / CLK_NS;
  localparam int ZQI_NS_DEFAULT = 128000000;
  localparam int ZQI_CYC        = ZQI_NS_DEFAULT / CLK_NS;
  localparam int CLK_RATIO      = 4;

  // Address fields
  localparam int ADDR_W = 29;

  typedef struct packed {
    logic [14:0] row;
    logic [9:0]  col;
    logic [1:0]  bank;
    logic [1:0]  group;
  } sdc_loc_t;

  typedef struct packed {
    logic [2:0] op;
    logic       rmw;
    logic       a10;
    logic       prio;
    sdc_loc_t   loc;
  } sdc_req_t;

  // Interleaved mapping, 4 GB single rank, x16 or x8
  function automatic sdc_loc_t sdc_map(input logic [ADDR_W-1:0] a, input logic x8);
    sdc_loc_t m;
    if (x8) begin
      m.row   = a[28:14];
      m.col   = {a[13:8], a[5], a[2:0]};
      m.bank  = {a[7], a[6]};
      m.group = {a[4], a[3]};
    end else begin
      m.row   = a[27:13];
      m.col   = {a[12:7], a[5], a[2:0]};
      m.bank  = {a[6], a[4]};
      m.group = {1'b0, a[3]};
    end
    return m;
  endfunction : sdc_map
endpackage : sdc_pkg

// [core/sdc_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sdc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [W-1:0]             in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic      [W-1:0]             out_data,
  output logic      [$clog2(DEPTH):0]   count
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("sdc_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } fst_t;

  fst_t q;
  fst_t n;
  logic push;
  logic pop;

  assign in_ready  = (q.cnt != DEPTH[PW:0]);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign count     = q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    n.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end
endmodule : sdc_fifo
`default_nettype wire

// [core/sdc_user_port.sv]
// SDRAM controller user port: request, write data, read return and maintenance
//Contract
// (R1) Command codes: write 000, read 001, masked write 011.
// (R2) With error correction, any masked write must use the masked-write code.
// (R3) Masked write triggers read-modify-write when error correction is on.
// (R4) Precharge input drives A10: low plain, high auto-precharge column command.
// (R5) Automatic precharge option ignores the input; controller decides A10.
// (R6) Request taken only when strobe and accept are both high.
// (R7) User holds request stable until accept is seen high.
// (R8) Accept low: uncalibrated, queue full, read/write slots full, periodic read.
// (R9) User data width is 2 x clocks-per-cycle x lane width minus check bits.
// (R10) One mask bit per byte; set bit leaves that byte unchanged.
// (R11) Write word taken only when data-valid and write-ready are high.
// (R12) User holds write data, valid and last flag while ready low.
// (R13) User marks final write word with the last-word flag.
// (R14) Write data lags its command by at most two cycles.
// (R15) Read data comes with valid and last-word flags.
// (R16) Maintenance requests pulse one cycle, then stay low until acknowledged.
// (R17) Acknowledge once the maintenance command reaches the physical layer.
// (R18) User clock is a quarter of memory clock; all ports sampled on it.
// (R19) User-side reset is driven synchronous to the user clock.
// (R20) Calibration-done rises when calibration ends; accept stays low before.
// (R21) Interleaved x8: group from bit 3, bank from 3 plus group width plus 1.
// (R22) x16 4 GB: row 27-13, column 12-7,5,2-0, bank 6,4, group 3.
// (R23) x8 4 GB: row 28-14, column 13-8,5,2-0, bank 7,6, group 4,3.
// (R24) Read data returns in request order.
// (R25) Default mode self-generates refresh and calibration; user inputs need user mode.
// (R26) Acknowledges are one-cycle pulses, only for requests actually made.
//
// Local design decisions: the control and status registers and the Wishbone interface to them.
`timescale 1ns/1ns
`default_nettype none
module sdc_user_port #(
  parameter int DQ_WIDTH   = 16,
  parameter int ECC_ON     = 0,
  parameter int ECC_WIDTH  = 0,
  parameter int RD_SLOTS   = 8,
  parameter int WR_SLOTS   = 4,
  parameter int CMD_DEPTH  = 4,
  parameter int WD_DEPTH   = 4,
  parameter int ZQI_CYCLES = sdc_pkg::ZQI_CYC,
  parameter int DW         = 2 * sdc_pkg::CLK_RATIO * (DQ_WIDTH - (ECC_ON != 0 ? ECC_WIDTH : 0)), // R9
  parameter int MW         = DW / 8
) (
  // Clock, reset, enable
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // Request handshake
  input  wire logic                          app_en,
  output logic                               app_rdy,
  input  wire logic [2:0]                    app_cmd,
  input  wire logic [sdc_pkg::ADDR_W-1:0]    app_addr,
  input  wire logic                          app_autoprecharge,
  input  wire logic                          request_priority,
  // Write data
  input  wire logic                          app_wdf_wren,
  output logic                               app_wdf_rdy,
  input  wire logic [DW-1:0]                 app_wdf_data,
  input  wire logic [MW-1:0]                 app_wdf_mask,
  input  wire logic                          app_wdf_end,
  // Read return
  output logic                               app_rd_data_valid,
  output logic                               app_rd_data_end,
  output logic      [DW-1:0]                 app_rd_data,
  // Maintenance
  input  wire logic                          user_refresh_request,
  output logic                               user_refresh_done,
  input  wire logic                          user_impedance_cal_request,
  output logic                               user_impedance_cal_done,
  // Status toward user
  output logic                               calib_done,
  output logic                               user_side_reset,
  // Controller core side
  input  wire logic                          init_calib_in,
  input  wire logic                          periodic_rd,
  output logic                               dn_valid,
  input  wire logic                          dn_ready,
  output sdc_pkg::sdc_req_t                  dn_req,
  output logic      [DW-1:0]                 dn_data,
  output logic      [MW-1:0]                 dn_mask,
  input  wire logic                          rtn_valid,
  input  wire logic [DW-1:0]                 rtn_data,
  output logic                               mnt_valid,
  output logic                               mnt_is_zq,
  input  wire logic                          mnt_ready,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o
);
  localparam int CW = sdc_pkg::CNT_W;
  localparam int QW = $bits(sdc_pkg::sdc_req_t);
  localparam int WW = DW + MW + 1;

  if (RD_SLOTS < 1 || RD_SLOTS > 255 || WR_SLOTS < 1 || WR_SLOTS > 255 || DW % 8 != 0
      || ZQI_CYCLES < 2) begin : g_chk
    $error("sdc_user_port parameters out of range");
  end

  typedef struct packed {
    logic          cal_s1;
    logic          cal_s2;
    logic          usr_rst;
    logic          auto_pre;
    logic          user_mnt;
    logic          map_x8;
    logic          wb_ack;
    logic [31:0]   wb_dat;
    logic [CW-1:0] rd_out;
    logic [CW-1:0] wr_pend;
    logic          ref_pend;
    logic          zq_pend;
    logic          ref_usr;
    logic          zq_usr;
    logic          ref_ack;
    logic          zq_ack;
    logic          rd_valid;
    logic          rd_end;
    logic [DW-1:0] rd_data;
    logic [15:0]   refi_cnt;
    logic [31:0]   zqi_cnt;
  } st_t;

  st_t                  q;
  st_t                  n;
  sdc_pkg::sdc_req_t    acc_req;
  sdc_pkg::sdc_req_t    head;
  logic                 is_rd;
  logic                 room;
  logic                 acc;
  logic                 cmd_ir;
  logic                 cmd_ov;
  logic [QW-1:0]        cmd_od;
  logic [$clog2(CMD_DEPTH):0] cmd_cnt;
  logic                 wd_ov;
  logic [WW-1:0]        wd_od;
  logic [$clog2(WD_DEPTH):0]  wd_cnt;
  logic                 hd_wr;
  logic                 dn_fire;
  logic                 mnt_fire;
  logic                 auto_ref;
  logic                 auto_zq;
  logic                 ref_set;
  logic                 zq_set;

  // Accept only with room for the request type
  assign is_rd   = (app_cmd == sdc_pkg::OP_RD);
  assign room    = is_rd ? (q.rd_out < CW'(RD_SLOTS)) : (q.wr_pend < CW'(WR_SLOTS));
  assign app_rdy = q.cal_s2 && cmd_ir && !periodic_rd && room; // R8 R20
  assign acc     = app_en && app_rdy; // R6

  always_comb begin
    acc_req      = '0;
    acc_req.op   = app_cmd; // R1
    acc_req.rmw  = (ECC_ON != 0) && (app_cmd == sdc_pkg::OP_WRB); // R3
    acc_req.a10  = app_autoprecharge;
    acc_req.prio = request_priority;
    acc_req.loc  = sdc_pkg::sdc_map(app_addr, q.map_x8); // R21 R22 R23
  end

  sdc_fifo #(.W(QW), .DEPTH(CMD_DEPTH)) u_cmd (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (acc),
    .in_ready  (cmd_ir),
    .in_data   (acc_req),
    .out_valid (cmd_ov),
    .out_ready (dn_fire),
    .out_data  (cmd_od),
    .count     (cmd_cnt)
  );

  // Write words carry data, mask and last flag
  sdc_fifo #(.W(WW), .DEPTH(WD_DEPTH)) u_wd (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (app_wdf_wren),
    .in_ready  (app_wdf_rdy),
    .in_data   ({app_wdf_end, app_wdf_mask, app_wdf_data}), // R11 R10
    .out_valid (wd_ov),
    .out_ready (dn_fire && hd_wr),
    .out_data  (wd_od),
    .count     (wd_cnt)
  );

  // A write waits at the head for its late data
  assign head     = sdc_pkg::sdc_req_t'(cmd_od);
  assign hd_wr    = (head.op != sdc_pkg::OP_RD);
  assign dn_valid = cmd_ov && (!hd_wr || wd_ov); // R14
  assign dn_fire  = dn_valid && dn_ready;
  assign dn_data  = wd_od[DW-1:0];
  assign dn_mask  = wd_od[DW+MW-1:DW]; // R10

  always_comb begin
    dn_req = head;
    // Close the page when nothing queues behind it
    if (q.auto_pre) begin
      dn_req.a10 = (cmd_cnt == 1); // R5
    end else begin
      dn_req.a10 = head.a10; // R4
    end
  end

  // Refresh before calibration when both wait
  assign mnt_valid = q.ref_pend || q.zq_pend;
  assign mnt_is_zq = !q.ref_pend;
  assign mnt_fire  = mnt_valid && mnt_ready;
  assign auto_ref  = !q.user_mnt && q.cal_s2 && (q.refi_cnt == 16'(sdc_pkg::REFI_CYC - 1));
  assign auto_zq   = !q.user_mnt && q.cal_s2 && (q.zqi_cnt == 32'(ZQI_CYCLES - 1));
  assign ref_set   = (q.user_mnt && user_refresh_request) || auto_ref; // R25
  assign zq_set    = (q.user_mnt && user_impedance_cal_request) || auto_zq; // R25

  always_comb begin
    n         = q;
    n.cal_s1  = init_calib_in;
    n.cal_s2  = q.cal_s1;
    n.usr_rst = 1'b0; // R19
    n.wb_ack  = 1'b0;
    if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
      n.wb_ack = 1'b1;
      n.wb_dat = 32'h0000_0000;
      if (wb_adr_i == sdc_pkg::CTRL_OFS) begin
        n.wb_dat[2:0] = {q.map_x8, q.user_mnt, q.auto_pre};
        if (wb_we_i && wb_sel_i[0]) begin
          n.auto_pre = wb_dat_i[sdc_pkg::CTRL_AUTO_PRE];
          n.user_mnt = wb_dat_i[sdc_pkg::CTRL_USER_MNT];
          n.map_x8   = wb_dat_i[sdc_pkg::CTRL_MAP_X8];
        end
      end else if (wb_adr_i == sdc_pkg::STAT_OFS) begin
        n.wb_dat = {8'h00, q.wr_pend, q.rd_out, 7'h00, q.cal_s2};
      end
    end
    n.rd_out  = q.rd_out + CW'(acc && is_rd) - CW'(rtn_valid);
    n.wr_pend = q.wr_pend + CW'(acc && !is_rd) - CW'(dn_fire && hd_wr);
    // Core returns reads in issue order; pass straight through
    n.rd_valid = rtn_valid; // R15 R24
    n.rd_end   = rtn_valid; // R15
    if (rtn_valid) begin
      n.rd_data = rtn_data;
    end
    // Interval counters only run in the self-maintained mode
    if (q.user_mnt || !q.cal_s2) begin
      n.refi_cnt = 16'h0000;
      n.zqi_cnt  = 32'h0000_0000;
    end else begin
      n.refi_cnt = auto_ref ? 16'h0000 : q.refi_cnt + 16'h0001;
      n.zqi_cnt  = auto_zq ? 32'h0000_0000 : q.zqi_cnt + 32'h0000_0001;
    end
    // New request wins over the clear in the same cycle
    n.ref_pend = (q.ref_pend && !(mnt_fire && !mnt_is_zq)) || ref_set;
    n.zq_pend  = (q.zq_pend && !(mnt_fire && mnt_is_zq)) || zq_set;
    if (ref_set) begin
      n.ref_usr = q.user_mnt;
    end
    if (zq_set) begin
      n.zq_usr = q.user_mnt;
    end
    n.ref_ack = mnt_fire && !mnt_is_zq && q.ref_usr; // R17 R26
    n.zq_ack  = mnt_fire && mnt_is_zq && q.zq_usr; // R17 R26
  end

  always_ff @(posedge mclk) begin // R18
    if (rst) begin
      q          <= '0;
      q.usr_rst  <= 1'b1;
      {q.map_x8, q.user_mnt, q.auto_pre} <= sdc_pkg::CTRL_RESET;
    end else if (ce) begin
      q <= n;
    end
  end

  assign app_rd_data_valid       = q.rd_valid;
  assign app_rd_data_end         = q.rd_end;
  assign app_rd_data             = q.rd_data;
  assign user_refresh_done       = q.ref_ack;
  assign user_impedance_cal_done = q.zq_ack;
  assign calib_done              = q.cal_s2; // R20
  assign user_side_reset         = q.usr_rst;
  assign wb_dat_o                = q.wb_dat;
  assign wb_ack_o                = q.wb_ack;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_accept_push;
    (cmd_cnt > $past(cmd_cnt)) |-> $past(app_en && app_rdy);
  endproperty
  a_accept_push: assert property (p_accept_push) else $error("command queued without handshake"); // R6

  property p_no_rdy_uncal;
    (!calib_done || periodic_rd) |-> !app_rdy;
  endproperty
  a_no_rdy_uncal: assert property (p_no_rdy_uncal) else $error("accept high while blocked"); // R8

  property p_rd_slots;
    (app_en && is_rd && q.rd_out >= CW'(RD_SLOTS)) |-> !app_rdy;
  endproperty
  a_rd_slots: assert property (p_rd_slots) else $error("read accepted with read buffer full"); // R8

  property p_wd_push;
    (wd_cnt > $past(wd_cnt)) |-> $past(app_wdf_wren && app_wdf_rdy);
  endproperty
  a_wd_push: assert property (p_wd_push) else $error("write word taken without handshake"); // R11

  property p_rmw;
    (dn_valid && dn_req.op == sdc_pkg::OP_WRB) |-> (dn_req.rmw == (ECC_ON != 0));
  endproperty
  a_rmw: assert property (p_rmw) else $error("masked write lacks read-modify-write"); // R3

  property p_a10_pin;
    (dn_valid && !q.auto_pre) |-> (dn_req.a10 == head.a10);
  endproperty
  a_a10_pin: assert property (p_a10_pin) else $error("A10 differs from request"); // R4

  property p_rd_return;
    (rtn_valid && ce) |=> (app_rd_data_valid && app_rd_data_end && app_rd_data == $past(rtn_data));
  endproperty
  a_rd_return: assert property (p_rd_return) else $error("read word lost or altered"); // R15

  property p_map_x16;
    (acc && !q.map_x8) |-> (acc_req.loc.row == app_addr[27:13] && acc_req.loc.bank == {app_addr[6], app_addr[4]});
  endproperty
  a_map_x16: assert property (p_map_x16) else $error("x16 mapping wrong"); // R22

  property p_ack_pulse;
    user_refresh_done |-> ($past(mnt_fire && !mnt_is_zq) ##1 !user_refresh_done);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("refresh acknowledge not a single pulse"); // R17 R26

  property p_no_auto_ack;
    (!q.user_mnt && !q.ref_usr && !q.zq_usr) |=> !(user_refresh_done || user_impedance_cal_done);
  endproperty
  a_no_auto_ack: assert property (p_no_auto_ack) else $error("acknowledge without user request"); // R25 R26

  c_read:  cover property (acc && is_rd ##[1:50] app_rd_data_valid);
  c_write: cover property (acc && !is_rd ##[1:20] (dn_fire && hd_wr));
  c_ref:   cover property (user_refresh_request ##[1:50] user_refresh_done);
endmodule : sdc_user_port
`default_nettype wire

// [sim/sdc_core_model.sv]
// Behavioural controller core behind the user port: takes requests, returns reads in order
`timescale 1ns/1ns
`default_nettype none
module sdc_core_model #(
  parameter int DW = 128
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              hold,
  // Request side
  input  wire logic              dn_valid,
  output logic                   dn_ready,
  input  wire sdc_pkg::sdc_req_t dn_req,
  // Read return
  output logic                   rtn_valid,
  output logic      [DW-1:0]     rtn_data,
  // Maintenance
  input  wire logic              mnt_valid,
  output logic                   mnt_ready
);
  sdc_pkg::sdc_loc_t pend[$];
  assign dn_ready  = !hold;
  assign mnt_ready = !hold;
  initial rtn_data = '0;
  always @(posedge mclk) begin
    rtn_valid <= 1'b0;
    // Idle bus toggles so stale data cannot pass as a match
    rtn_data  <= ~rtn_data;
    if (rst) begin
      pend.delete();
    end else begin
      if (dn_valid && !hold && dn_req.op == sdc_pkg::OP_RD) begin
        pend.push_back(dn_req.loc);
      end
      if (pend.size() > 0 && !hold) begin
        rtn_valid <= 1'b1;
        rtn_data  <= DW'(pend.pop_front());
      end
    end
  end
endmodule : sdc_core_model
`default_nettype wire

// [sim/sdc_user_port_tb.sv]
// Self-checking bench of the SDRAM user port
`timescale 1ns/1ns
`default_nettype none
module sdc_user_port_tb;
  localparam int DW = 128;
  localparam int MW = 16;
  logic              mclk, rst, ce, app_en, app_rdy, app_autoprecharge, request_priority;
  logic [2:0]        app_cmd;
  logic [28:0]       app_addr;
  logic              app_wdf_wren, app_wdf_rdy, app_wdf_end, app_rd_data_valid, app_rd_data_end;
  logic [DW-1:0]     app_wdf_data, app_rd_data, dn_data, rtn_data;
  logic [MW-1:0]     app_wdf_mask, dn_mask;
  logic              user_refresh_request, user_refresh_done, user_impedance_cal_request;
  logic              user_impedance_cal_done, calib_done, user_side_reset, init_calib_in, periodic_rd;
  logic              dn_valid, dn_ready, rtn_valid, mnt_valid, mnt_is_zq, mnt_ready, hold;
  logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o;
  sdc_pkg::sdc_req_t dn_req;
  sdc_pkg::sdc_req_t req_q[$];
  logic [DW+MW-1:0]  wr_q[$];
  logic [DW-1:0]     rd_q[$];
  int                miscompares, tests_run, ref_acks, zq_acks;

  sdc_user_port #(.ZQI_CYCLES(50)) dut (.*);
  sdc_core_model #(.DW(DW)) partner (.mclk(mclk), .rst(rst), .hold(hold), .dn_valid(dn_valid),
    .dn_ready(dn_ready), .dn_req(dn_req), .rtn_valid(rtn_valid), .rtn_data(rtn_data),
    .mnt_valid(mnt_valid), .mnt_ready(mnt_ready));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Monitor at the falling edge, where every output has settled
  always @(negedge mclk) begin
    if (dn_valid && dn_ready) begin
      req_q.push_back(dn_req);
      wr_q.push_back({dn_mask, dn_data});
    end
    if (app_rd_data_valid) begin
      rd_q.push_back(app_rd_data);
      chk(app_rd_data_end, 1'b1);
    end
    ref_acks += user_refresh_done;
    zq_acks  += user_impedance_cal_done;
  end

  function automatic sdc_pkg::sdc_loc_t exp_loc(input logic [28:0] a, input logic x8);
    exp_loc = x8 ? {a[28:14], a[13:8], a[5], a[2:0], a[7], a[6], a[4], a[3]}
                 : {a[27:13], a[12:7], a[5], a[2:0], a[6], a[4], 1'b0, a[3]};
  endfunction : exp_loc

  // Ends at the falling edge where s is high; the next rising edge completes the handshake
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge mclk);
    while (s !== 1'b1 && n < 100) begin
      n++;
      @(negedge mclk);
    end
    chk(n < 100, 1'b1);
  endtask : wait_hi

  task automatic put(input logic [2:0] c, input logic [28:0] a, input logic ap);
    app_en            <= 1'b1;
    app_cmd           <= c;
    app_addr          <= a;
    app_autoprecharge <= ap;
  endtask : put

  task automatic req(input logic [2:0] c, input logic [28:0] a, input logic ap);
    put(c, a, ap);
    wait_hi(app_rdy);
    @(posedge mclk);
  endtask : req

  task automatic wdat(input logic [DW-1:0] d, input logic [MW-1:0] m);
    app_wdf_wren <= 1'b1;
    app_wdf_data <= d;
    app_wdf_mask <= m;
    app_wdf_end  <= 1'b1;
    wait_hi(app_wdf_rdy);
    @(posedge mclk);
  endtask : wdat

  task automatic idle(input int n);
    app_en       <= 1'b0;
    app_wdf_wren <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wait_hi(wb_ack_o);
    if (!we) begin
      chk(wb_dat_o, d);
    end
    @(posedge mclk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : wb

  // Pops the next issued request; reads also pop returned data, writes their paired word
  task automatic chk_req(input logic [2:0] op, input logic [28:0] a, input logic x8, input logic a10,
                         input logic [DW-1:0] d, input logic [MW-1:0] m);
    sdc_pkg::sdc_req_t r;
    int                n;
    n = 0;
    while ((req_q.size() == 0 || (op == sdc_pkg::OP_RD && rd_q.size() == 0)) && n < 50) begin
      n++;
      @(negedge mclk);
    end
    chk(n < 50, 1'b1);
    r = req_q.pop_front();
    chk(r.op, op);
    chk(r.rmw, 1'b0);
    chk(r.prio, request_priority);
    chk(r.a10, a10);
    chk(r.loc, exp_loc(a, x8));
    if (op == sdc_pkg::OP_RD) begin
      chk(rd_q.pop_front(), DW'(exp_loc(a, x8)));
      void'(wr_q.pop_front());
    end else begin
      chk(wr_q.pop_front(), {m, d});
    end
  endtask : chk_req

  task automatic t_cal();
    @(posedge mclk);
    put(sdc_pkg::OP_RD, 29'h1234_5678, 1'b0);
    repeat (4) begin
      @(negedge mclk);
      chk(app_rdy, 1'b0);
      chk(calib_done, 1'b0);
    end
    @(posedge mclk);
    init_calib_in <= 1'b1;
    wait_hi(app_rdy);
    @(posedge mclk);
    idle(3);
    @(negedge mclk);
    chk(calib_done, 1'b1);
    chk(req_q.size(), 1);
    chk_req(sdc_pkg::OP_RD, 29'h1234_5678, 1'b0, 1'b0, '0, '0);
    @(posedge mclk);
  endtask : t_cal

  task automatic t_regs();
    wb(1'b0, sdc_pkg::CTRL_OFS, 32'h0000_0000);
    wb(1'b1, sdc_pkg::CTRL_OFS, 32'hffff_ffff);
    wb(1'b0, sdc_pkg::CTRL_OFS, 32'h0000_0007);
    wb(1'b1, sdc_pkg::STAT_OFS, 32'hffff_ffff);
    wb(1'b0, sdc_pkg::STAT_OFS, 32'h0000_0001);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
  endtask : t_regs

  task automatic t_rd(input logic x8);
    wb(1'b1, sdc_pkg::CTRL_OFS, {29'h0, x8, 2'b00});
    req(sdc_pkg::OP_RD, 29'h1abc_def5, 1'b0);
    req(sdc_pkg::OP_RD, 29'h0246_8ace, 1'b0);
    idle(2);
    chk_req(sdc_pkg::OP_RD, 29'h1abc_def5, x8, 1'b0, '0, '0);
    chk_req(sdc_pkg::OP_RD, 29'h0246_8ace, x8, 1'b0, '0, '0);
    @(posedge mclk);
  endtask : t_rd

  // Data queued ahead of its commands while the core stalls, until the FIFO refuses
  task automatic t_wfill();
    wb(1'b1, sdc_pkg::CTRL_OFS, 32'h0000_0000);
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wdat(DW'(i + 1), i[0] ? 16'h00ff : 16'h0000);
    end
    @(negedge mclk);
    chk(app_wdf_rdy, 1'b0);
    @(posedge mclk);
    app_wdf_wren <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      req(i[0] ? sdc_pkg::OP_WRB : sdc_pkg::OP_WR, 29'(i * 8), i[0]);
    end
    // Core stalled: queue and write slots full
    @(negedge mclk);
    chk(app_rdy, 1'b0);
    @(posedge mclk);
    hold <= 1'b0;
    idle(2);
    for (int i = 0; i < 4; i++) begin
      chk_req(i[0] ? sdc_pkg::OP_WRB : sdc_pkg::OP_WR, 29'(i * 8), 1'b0, i[0], DW'(i + 1),
              i[0] ? 16'h00ff : 16'h0000);
    end
    @(posedge mclk);
  endtask : t_wfill

  task automatic t_wlag();
    req(sdc_pkg::OP_WRB, 29'h0000_0123, 1'b1);
    app_en <= 1'b0;
    @(posedge mclk);
    wdat(128'h5, 16'h0003);
    idle(3);
    chk_req(sdc_pkg::OP_WRB, 29'h0000_0123, 1'b0, 1'b1, 128'h5, 16'h0003);
    @(posedge mclk);
  endtask : t_wlag

  task automatic t_per();
    periodic_rd <= 1'b1;
    put(sdc_pkg::OP_RD, 29'h0000_0040, 1'b0);
    repeat (3) begin
      @(negedge mclk);
      chk(app_rdy, 1'b0);
    end
    @(posedge mclk);
    periodic_rd <= 1'b0;
    wait_hi(app_rdy);
    @(posedge mclk);
    idle(2);
    chk_req(sdc_pkg::OP_RD, 29'h0000_0040, 1'b0, 1'b0, '0, '0);
    @(posedge mclk);
  endtask : t_per

  // Lone request in automatic precharge mode gets A10 despite a low input
  task automatic t_auto();
    wb(1'b1, sdc_pkg::CTRL_OFS, 32'h0000_0001);
    request_priority <= 1'b1;
    req(sdc_pkg::OP_RD, 29'h0000_0800, 1'b0);
    idle(2);
    chk_req(sdc_pkg::OP_RD, 29'h0000_0800, 1'b0, 1'b1, '0, '0);
    @(posedge mclk);
  endtask : t_auto

  task automatic t_mnt(input logic [31:0] ctl, input int n);
    wb(1'b1, sdc_pkg::CTRL_OFS, ctl);
    ref_acks = 0;
    zq_acks  = 0;
    user_refresh_request       <= 1'b1;
    user_impedance_cal_request <= 1'b1;
    @(posedge mclk);
    user_refresh_request       <= 1'b0;
    user_impedance_cal_request <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(ref_acks, n);
    chk(zq_acks, n);
  endtask : t_mnt

  initial begin
    {rst, ce, request_priority, app_en, app_autoprecharge, app_wdf_wren, app_wdf_end} = '1;
    {ce, request_priority, app_en, app_autoprecharge, app_wdf_wren, app_wdf_end} = '0;
    ce = 1'b1;
    {app_cmd, app_addr, app_wdf_data, app_wdf_mask, hold, periodic_rd, init_calib_in} = '0;
    {user_refresh_request, user_impedance_cal_request, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, miscompares, tests_run, ref_acks, zq_acks} = '0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk(user_side_reset, 1'b1);
    @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(user_side_reset, 1'b0);
    t_cal();
    t_regs();
    t_rd(1'b0);
    t_rd(1'b1);
    t_wfill();
    t_wlag();
    t_per();
    t_auto();
    t_mnt(32'h0000_0000, 0);
    t_mnt(32'h0000_0002, 1);
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
endmodule : sdc_user_port_tb
`default_nettype wire
